// *** inc/cdcb_defines.svh ***
// constants of the camera device control bank: offsets, reset values, timing
`ifndef CDCB_DEFINES_SVH
`define CDCB_DEFINES_SVH

// ---------------------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------------------
`define CDCB_CLK_HZ 200000000
`define CDCB_SEC_S 1
`define CDCB_SEC_CYCLES (`CDCB_SEC_S * `CDCB_CLK_HZ)
`define CDCB_FLASH_MS 500
`define CDCB_FLASH_CYCLES (`CDCB_FLASH_MS * (`CDCB_CLK_HZ / 1000))
`define CDCB_RESP_MS 32'h00000064
`define CDCB_MAX_PKT 16'h0400

// ---------------------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------------------
`define CDCB_OFF_FW_VER 8'h00
`define CDCB_OFF_PL_VER 8'h04
`define CDCB_OFF_ENDIAN 8'h08
`define CDCB_OFF_UPTIME 8'h0c
`define CDCB_OFF_LINK_SPEED 8'h10
`define CDCB_OFF_TS_LATCH 8'h14
`define CDCB_OFF_TS_LO 8'h18
`define CDCB_OFF_TS_HI 8'h1c
`define CDCB_OFF_TS_MAX_LO 8'h20
`define CDCB_OFF_TS_MAX_HI 8'h24
`define CDCB_OFF_LIMIT_MODE 8'h28
`define CDCB_OFF_LINK_LIMIT 8'h2c
`define CDCB_OFF_LINK_CUR 8'h30
`define CDCB_OFF_SENSOR_LIMIT 8'h34
`define CDCB_OFF_DEV_RESET 8'h38
`define CDCB_OFF_TEMP_SEL 8'h3c
`define CDCB_OFF_TEMP 8'h40
`define CDCB_OFF_LOCATE 8'h44
`define CDCB_OFF_RESP_TIME 8'h48
`define CDCB_NAME_SEL 2'h2

// ---------------------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------------------
`define CDCB_CMD_BIT 0
`define CDCB_PROTO_ENDIAN 1'h0
`define CDCB_IMPL_ENDIAN 1'h0
`define CDCB_TS_MAX 64'hffffffffffffffff
`define CDCB_LIMIT_MODE_RST 1'h0
`define CDCB_LINK_LIMIT_RST 32'h17d78400
`define CDCB_SENSOR_LIMIT_RST 32'h17d78400

`endif

// *** inc/cdcb_pkg.sv ***
// types shared by the camera device control bank modules
`include "cdcb_defines.svh"

package cdcb_pkg;

  // -------------------------------------------------------------------------
  // bus handshake states, gray along idle -> fetch -> ack
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CDCB_IDLE = 2'h0,
    CDCB_FETCH = 2'h1,
    CDCB_ACK = 2'h3
  } cdcb_bus_t;

  typedef struct packed {
    cdcb_bus_t bus;
    logic waitreq;
    logic [31:0] rdata;
    logic [15:0] name_valid;
    logic [63:0] ts;
    logic [63:0] ts_latched;
    logic [31:0] sec_cnt;
    logic [31:0] uptime;
    logic super_speed;
    logic limit_mode;
    logic [31:0] link_limit;
    logic [31:0] cur_bytes;
    logic [31:0] cur_thru;
    logic [31:0] sensor_limit;
    logic temp_sel;
    logic [31:0] flash_cnt;
    logic led;
    logic soft_rst;
  } cdcb_state_t;

  typedef struct packed {
    logic [15:0][31:0] mem;
    logic [31:0] rdata;
  } cdcb_mem_t;

  typedef struct packed {
    logic [47:0] credit;
    logic grant;
    logic [15:0] len;
  } cdcb_pacer_t;

endpackage

// *** design/cdcb_name_mem.sv ***
// word store for the host assigned name, registered read port
module cdcb_name_mem
  import cdcb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [3:0] waddr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] be_i,
  input wire logic [3:0] raddr_i,
  output logic [31:0] rdata_o
);

  cdcb_mem_t s;
  cdcb_mem_t next_s;
  logic [31:0] wmask;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[8*gi +: 8] = {8{be_i[gi]}};
    end
  endgenerate

  always_comb begin
    next_s = s;
    next_s.rdata = s.mem[raddr_i];
    if (we_i) begin
      next_s.mem[waddr_i] = (s.mem[waddr_i] & ~wmask) | (wdata_i & wmask);
    end
    // contents need no reset: the owner tracks which words are valid
    if (rst_i) begin
      next_s.rdata = 32'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    s <= next_s;
  end

  assign rdata_o = s.rdata;

endmodule // cdcb_name_mem

// *** design/cdcb_link_pacer.sv ***
// credit based pacer that spaces transport packets under a byte rate limit
`include "cdcb_defines.svh"
module cdcb_link_pacer
  import cdcb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic [31:0] limit_i,
  input wire logic req_i,
  input wire logic [15:0] len_i,
  output logic grant_o,
  output logic [15:0] len_o
);

  cdcb_pacer_t s;
  cdcb_pacer_t next_s;
  logic [47:0] cost;
  logic [47:0] cap;
  logic [47:0] base;
  logic [47:0] sum;
  logic go;

  always_comb begin
    next_s = s;
    // one packet costs len * clock rate; one cycle earns the limit in bytes
    cost = 48'(len_i) * 48'(`CDCB_CLK_HZ);
    cap = 48'(`CDCB_MAX_PKT) * 48'(`CDCB_CLK_HZ);
    if (cost > cap) begin
      cap = cost;
    end
    go = 1'b0;
    if (req_i && !s.grant) begin
      if (!enable_i) begin
        go = 1'b1;
      end else if (s.credit >= cost) begin
        go = 1'b1;
      end
    end
    base = (go && enable_i) ? s.credit - cost : s.credit;
    sum = base + 48'(limit_i);
    // cap stops idle time turning into a burst above the limit
    next_s.credit = (sum > cap) ? cap : sum;
    next_s.grant = go;
    if (go) begin
      next_s.len = len_i;
    end
    if (rst_i) begin
      next_s = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    s <= next_s;
  end

  assign grant_o = s.grant;
  assign len_o = s.len;

endmodule // cdcb_link_pacer

// *** design/cdcb_device_control.sv ***
// camera device control bank: avalon-mm register slave with its device logic
//
// Behaviour
// - The host-assigned name is writable and reads back as zeros after reset until written.
// - Writing the latch command copies the running timestamp counter into the timestamp registers.
// - When limiting, packet grants are spaced evenly so the byte rate never exceeds the limit.
// - A read-only register shows the bytes sent on the link during the last full second.
// - Writing the reset command resets the bank except the uptime count and pulses the device reset output.
// - Writing the locate command lights the red indicator for one single flash.
// - A writable selector picks which component temperature the temperature register shows.
// - A read-only uptime register counts whole seconds since power came up.
// - A read-only register shows whether the link runs at super speed or high speed.
// - A writable sensor throughput limit drives the sensor flow limit output.
// - Firmware and logic versions read back from two read-only registers.
// - The largest value the timestamp can reach reads back from two read-only registers.
// - The protocol and implementation byte orders read back from one read-only register.
`include "cdcb_defines.svh"
module cdcb_device_control
  import cdcb_pkg::*;
#(
  parameter logic [31:0] FW_VERSION = 32'h00010000,
  parameter logic [31:0] PL_VERSION = 32'h00010000,
  parameter int SEC_CYCLES = `CDCB_SEC_CYCLES,
  parameter int FLASH_CYCLES = `CDCB_FLASH_CYCLES
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic USB_SUPER_SPEED_I,
  input wire logic [15:0] TEMP_BOARD_I,
  input wire logic [15:0] TEMP_SENSOR_I,
  input wire logic PKT_REQ_I,
  input wire logic [15:0] PKT_LEN_I,
  output logic PKT_GRANT_O,
  output logic [31:0] SENSOR_LIMIT_O,
  output logic LED_RED_O,
  output logic DEVICE_RESET_O
);

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  cdcb_state_t s;
  cdcb_state_t next_s;
  logic [7:0] word_addr;
  logic name_hit;
  logic [3:0] name_idx;
  logic [31:0] wmask;
  logic [31:0] merged_link;
  logic [31:0] merged_sensor;
  logic cmd;
  logic wr_ack;
  logic [31:0] rd_val;
  logic [31:0] mem_rdata;
  logic mem_we;
  logic [31:0] mem_wdata;
  logic [3:0] mem_be;
  logic [15:0] temp_sel_val;
  logic grant;
  logic [15:0] grant_len;
  logic [31:0] grant_bytes;
  logic tick;
  logic sub_rst;

  assign word_addr = {AVS_ADDRESS_I[7:2], 2'h0};
  assign name_hit = (AVS_ADDRESS_I[7:6] == `CDCB_NAME_SEL);
  assign name_idx = AVS_ADDRESS_I[5:2];
  assign cmd = AVS_WRITEDATA_I[`CDCB_CMD_BIT] && AVS_BYTEENABLE_I[0];
  assign wr_ack = (s.bus == CDCB_ACK) && AVS_WRITE_I;
  assign sub_rst = RESET_I || s.soft_rst;

  // ---------------------------------------------------------------------------
  // byte lane masks
  // ---------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[8*gi +: 8] = {8{AVS_BYTEENABLE_I[gi]}};
    end
  endgenerate

  assign merged_link = (s.link_limit & ~wmask) | (AVS_WRITEDATA_I & wmask);
  assign merged_sensor = (s.sensor_limit & ~wmask) | (AVS_WRITEDATA_I & wmask);

  // ---------------------------------------------------------------------------
  // name store
  // ---------------------------------------------------------------------------
  always_comb begin
    mem_we = wr_ack && name_hit;
    // a fresh word takes zeros in the lanes not written, so it never shows stale data
    if (s.name_valid[name_idx]) begin
      mem_be = AVS_BYTEENABLE_I;
      mem_wdata = AVS_WRITEDATA_I;
    end else begin
      mem_be = 4'hf;
      mem_wdata = AVS_WRITEDATA_I & wmask;
    end
  end

  cdcb_name_mem u_name_mem (
    .clk_i(CLK_I),
    .rst_i(sub_rst),
    .we_i(mem_we),
    .waddr_i(name_idx),
    .wdata_i(mem_wdata),
    .be_i(mem_be),
    .raddr_i(name_idx),
    .rdata_o(mem_rdata)
  );

  // ---------------------------------------------------------------------------
  // link pacing
  // ---------------------------------------------------------------------------
  cdcb_link_pacer u_pacer (
    .clk_i(CLK_I),
    .rst_i(sub_rst),
    .enable_i(s.limit_mode),
    .limit_i(s.link_limit),
    .req_i(PKT_REQ_I),
    .len_i(PKT_LEN_I),
    .grant_o(grant),
    .len_o(grant_len)
  );

  assign grant_bytes = grant ? 32'(grant_len) : 32'h0;
  assign tick = (s.sec_cnt == 32'(SEC_CYCLES - 1));

  // ---------------------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------------------
  always_comb begin
    temp_sel_val = s.temp_sel ? TEMP_SENSOR_I : TEMP_BOARD_I;
    rd_val = 32'h0;
    if (name_hit) begin
      rd_val = s.name_valid[name_idx] ? mem_rdata : 32'h0;
    end else begin
      case (word_addr)
        `CDCB_OFF_FW_VER: rd_val = FW_VERSION;
        `CDCB_OFF_PL_VER: rd_val = PL_VERSION;
        `CDCB_OFF_ENDIAN: rd_val = {30'h0, `CDCB_IMPL_ENDIAN, `CDCB_PROTO_ENDIAN};
        `CDCB_OFF_UPTIME: rd_val = s.uptime;
        `CDCB_OFF_LINK_SPEED: rd_val = {31'h0, s.super_speed};
        `CDCB_OFF_TS_LO: rd_val = s.ts_latched[31:0];
        `CDCB_OFF_TS_HI: rd_val = s.ts_latched[63:32];
        `CDCB_OFF_TS_MAX_LO: rd_val = 32'(`CDCB_TS_MAX);
        `CDCB_OFF_TS_MAX_HI: rd_val = 32'(`CDCB_TS_MAX >> 32);
        `CDCB_OFF_LIMIT_MODE: rd_val = {31'h0, s.limit_mode};
        `CDCB_OFF_LINK_LIMIT: rd_val = s.link_limit;
        `CDCB_OFF_LINK_CUR: rd_val = s.cur_thru;
        `CDCB_OFF_SENSOR_LIMIT: rd_val = s.sensor_limit;
        `CDCB_OFF_TEMP_SEL: rd_val = {31'h0, s.temp_sel};
        `CDCB_OFF_TEMP: rd_val = {{16{temp_sel_val[15]}}, temp_sel_val};
        `CDCB_OFF_LOCATE: rd_val = {31'h0, s.led};
        `CDCB_OFF_RESP_TIME: rd_val = `CDCB_RESP_MS;
        default: rd_val = 32'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.soft_rst = 1'b0;
    next_s.super_speed = USB_SUPER_SPEED_I;
    next_s.ts = s.ts + 64'h1;

    if (tick) begin
      next_s.sec_cnt = 32'h0;
      next_s.uptime = s.uptime + 32'h1;
      next_s.cur_thru = s.cur_bytes + grant_bytes;
      next_s.cur_bytes = 32'h0;
    end else begin
      next_s.sec_cnt = s.sec_cnt + 32'h1;
      next_s.cur_bytes = s.cur_bytes + grant_bytes;
    end

    if (s.flash_cnt != 32'h0) begin
      next_s.flash_cnt = s.flash_cnt - 32'h1;
    end

    case (s.bus)
      CDCB_IDLE: begin
        if (AVS_READ_I || AVS_WRITE_I) begin
          next_s.bus = CDCB_FETCH;
        end
      end
      CDCB_FETCH: begin
        // one spare cycle lets the name store present its registered word
        next_s.bus = CDCB_ACK;
        next_s.waitreq = 1'b0;
        next_s.rdata = AVS_READ_I ? rd_val : 32'h0;
      end
      CDCB_ACK: begin
        next_s.bus = CDCB_IDLE;
        next_s.waitreq = 1'b1;
        if (AVS_WRITE_I) begin
          if (name_hit) begin
            next_s.name_valid[name_idx] = 1'b1;
          end else begin
            case (word_addr)
              `CDCB_OFF_TS_LATCH: begin
                if (cmd) begin
                  next_s.ts_latched = s.ts;
                end
              end
              `CDCB_OFF_LIMIT_MODE: begin
                if (AVS_BYTEENABLE_I[0]) begin
                  next_s.limit_mode = AVS_WRITEDATA_I[0];
                end
              end
              `CDCB_OFF_LINK_LIMIT: next_s.link_limit = merged_link;
              `CDCB_OFF_SENSOR_LIMIT: next_s.sensor_limit = merged_sensor;
              `CDCB_OFF_DEV_RESET: begin
                if (cmd) begin
                  next_s.soft_rst = 1'b1;
                end
              end
              `CDCB_OFF_TEMP_SEL: begin
                if (AVS_BYTEENABLE_I[0]) begin
                  next_s.temp_sel = AVS_WRITEDATA_I[0];
                end
              end
              `CDCB_OFF_LOCATE: begin
                // start flash, a second command during a flash is dropped
                if (cmd && s.flash_cnt == 32'h0) begin
                  next_s.flash_cnt = 32'(FLASH_CYCLES);
                end
              end
              default: begin
              end
            endcase
          end
        end
      end
      default: begin
        next_s.bus = CDCB_IDLE;
        next_s.waitreq = 1'b1;
      end
    endcase

    next_s.led = (next_s.flash_cnt != 32'h0);

    // full reset; on the reset command uptime survives since power stays applied
    if (sub_rst) begin
      next_s = '0;
      next_s.bus = CDCB_IDLE;
      next_s.waitreq = 1'b1;
      next_s.limit_mode = `CDCB_LIMIT_MODE_RST;
      next_s.link_limit = `CDCB_LINK_LIMIT_RST;
      next_s.sensor_limit = `CDCB_SENSOR_LIMIT_RST;
      next_s.super_speed = USB_SUPER_SPEED_I;
      if (!RESET_I) begin
        next_s.uptime = tick ? s.uptime + 32'h1 : s.uptime;
        next_s.sec_cnt = tick ? 32'h0 : s.sec_cnt + 32'h1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // state register and outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    s <= next_s;
  end

  assign AVS_READDATA_O = s.rdata;
  assign AVS_WAITREQUEST_O = s.waitreq;
  assign PKT_GRANT_O = grant;
  assign SENSOR_LIMIT_O = s.sensor_limit;
  assign LED_RED_O = s.led;
  assign DEVICE_RESET_O = s.soft_rst;

endmodule // cdcb_device_control

// *** dv/cdcb_ctl_asserts.sv ***
// concurrent checks on the ports of the device control bank
module cdcb_ctl_asserts (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic PKT_REQ_I,
  input wire logic PKT_GRANT_O,
  input wire logic [31:0] SENSOR_LIMIT_O,
  input wire logic LED_RED_O,
  input wire logic DEVICE_RESET_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wack;
  logic cmd0;
  logic [31:0] wd_q;
  assign wack = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  assign cmd0 = AVS_WRITEDATA_I[0] && AVS_BYTEENABLE_I[0];
  // accepted write data, kept so the sensor limit copy can be compared later
  always_ff @(posedge CLK_I) begin
    if (wack) begin
      wd_q <= AVS_WRITEDATA_I;
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // ---------------------------------------------------------------------------
  // bus, sensor limit, pacer, indicator and reset command
  // ---------------------------------------------------------------------------
  property p_ack_once; !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O; endproperty
  a_ack_once: assert property (p_ack_once) else $error("waitrequest low two cycles");
  property p_ack_bound; (AVS_READ_I || AVS_WRITE_I) |-> ##[0:3] !AVS_WAITREQUEST_O; endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("request not answered in time");
  property p_sensor; wack && AVS_ADDRESS_I[7:2] == 6'h0d && AVS_BYTEENABLE_I == 4'hf |=> ##[0:1] SENSOR_LIMIT_O == wd_q; endproperty
  a_sensor: assert property (p_sensor) else $error("sensor limit output not updated");
  property p_led_cause; $rose(LED_RED_O) |-> $past(wack && AVS_ADDRESS_I[7:2] == 6'h11 && cmd0); endproperty
  a_led_cause: assert property (p_led_cause) else $error("indicator lit without locate");
  property p_led_hold; $rose(LED_RED_O) |-> LED_RED_O [*8]; endproperty
  a_led_hold: assert property (p_led_hold) else $error("flash too short");
  property p_dev_rst; DEVICE_RESET_O |-> $past(wack && AVS_ADDRESS_I[7:2] == 6'h0e && cmd0) ##1 !DEVICE_RESET_O; endproperty
  a_dev_rst: assert property (p_dev_rst) else $error("device reset pulse wrong");
  property p_grant_gap; PKT_GRANT_O |=> !PKT_GRANT_O; endproperty
  a_grant_gap: assert property (p_grant_gap) else $error("grants in adjacent cycles");
  property p_grant_req; $rose(PKT_GRANT_O) |-> $past(PKT_REQ_I); endproperty
  a_grant_req: assert property (p_grant_req) else $error("grant without request");
endmodule // cdcb_ctl_asserts

bind cdcb_device_control cdcb_ctl_asserts u_chk (.CLK_I, .RESET_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I,
  .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I, .AVS_WAITREQUEST_O, .PKT_REQ_I, .PKT_GRANT_O, .SENSOR_LIMIT_O, .LED_RED_O,
  .DEVICE_RESET_O);

// *** dv/cdcb_pkt_source.sv ***
// packet source on the transport side of the link pacer
module cdcb_pkt_source (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [15:0] len_i,
  input wire logic grant_i,
  output logic req_o,
  output logic [15:0] len_o,
  output int grants_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // request and length held until granted; a released length shows its inverse
  always @(posedge clk_i) begin
    if (rst_i) begin
      req_o <= 1'b0;
      len_o <= ~len_i;
      grants_o <= 0;
    end else if (grant_i) begin
      req_o <= 1'b0;
      len_o <= ~len_o;
      grants_o <= grants_o + 1;
    end else if (run_i && !req_o) begin
      req_o <= 1'b1;
      len_o <= len_i;
    end
  end
endmodule // cdcb_pkt_source

// *** dv/testbench.sv ***
// self-checking bench for the camera device control bank
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 20;
  localparam int FLASH = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hf;
  logic fast = 1'b1;
  logic [15:0] t_brd = 16'hfff6;
  logic [15:0] t_sns = 16'h0019;
  logic run = 1'b0;
  logic [31:0] rdata, slim, q;
  logic waitreq, req, grant, led, dev_rst;
  logic [15:0] len;
  int grants, ack_cyc, cyc = 0, led_cyc = 0, pulses = 0;
  int n_errors = 0;
  int n_compared = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) if (led === 1'b1) led_cyc <= led_cyc + 1;
  always @(posedge clk) if (dev_rst === 1'b1) pulses <= pulses + 1;
  cdcb_device_control #(.SEC_CYCLES(SEC), .FLASH_CYCLES(FLASH)) u_dut (
    .CLK_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
    .USB_SUPER_SPEED_I(fast), .TEMP_BOARD_I(t_brd), .TEMP_SENSOR_I(t_sns), .PKT_REQ_I(req),
    .PKT_LEN_I(len), .PKT_GRANT_O(grant), .SENSOR_LIMIT_O(slim), .LED_RED_O(led), .DEVICE_RESET_O(dev_rst));
  cdcb_pkt_source u_src (.clk_i(clk), .rst_i(rst), .run_i(run), .len_i(16'h0400), .grant_i(grant),
    .req_o(req), .len_o(len), .grants_o(grants));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one access; ends with a spare edge so the next request never lands in the release time step
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    rd <= ~w;
    wr <= w;
    @(posedge clk);
    // no limit of its own: only the watchdog ends a wait that never comes
    while (waitreq !== 1'b0) begin
      @(posedge clk);
      n++;
    end
    chk("wait cycles", 32'h2, 32'(n));
    q = rdata;
    ack_cyc = cyc;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_ident();
    logic [7:0] a [8];
    logic [31:0] v [8];
    a = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h20, 8'h24, 8'h48, 8'h4c};
    v = '{32'h00010000, 32'h00010000, 32'h0, 32'h1, 32'hffffffff, 32'hffffffff, 32'h64, 32'h0};
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, a[i], 32'h0);
      chk("ro", v[i], q);
      bus(1'b1, a[i], 32'h5a5a5a5a);
      bus(1'b0, a[i], 32'h0);
      chk("ro kept", v[i], q);
    end
    fast <= 1'b0;
    bus(1'b0, 8'h10, 32'h0);
    chk("high speed", 32'h0, q);
    fast <= 1'b1;
  endtask
  task automatic t_name();
    bus(1'b0, 8'h84, 32'h0);
    chk("name empty", 32'h0, q);
    bus(1'b1, 8'h84, 32'h12345678);
    bus(1'b0, 8'h84, 32'h0);
    chk("name", 32'h12345678, q);
    be <= 4'h1;
    bus(1'b1, 8'hbc, 32'haabbccdd);
    be <= 4'hf;
    bus(1'b0, 8'hbc, 32'h0);
    chk("name lane", 32'h000000dd, q);
  endtask
  task automatic t_stamp();
    int a1;
    logic [31:0] l1;
    bus(1'b1, 8'h14, 32'h1);
    a1 = ack_cyc;
    bus(1'b0, 8'h18, 32'h0);
    l1 = q;
    bus(1'b1, 8'h14, 32'h1);
    a1 = ack_cyc - a1;
    bus(1'b0, 8'h18, 32'h0);
    chk("stamp step", 32'(a1), q - l1);
  endtask
  task automatic t_temp();
    bus(1'b1, 8'h3c, 32'h0);
    bus(1'b0, 8'h40, 32'h0);
    chk("temp board", 32'hfffffff6, q);
    bus(1'b1, 8'h3c, 32'h1);
    bus(1'b0, 8'h40, 32'h0);
    chk("temp sensor", 32'h00000019, q);
  endtask
  task automatic t_uptime();
    int a0;
    logic [31:0] u0;
    bus(1'b0, 8'h0c, 32'h0);
    a0 = ack_cyc;
    u0 = q;
    while (cyc < a0 + 2 * SEC - 3) @(posedge clk);
    bus(1'b0, 8'h0c, 32'h0);
    chk("uptime step", 32'h2, q - u0);
  endtask
  task automatic t_sensor();
    bus(1'b1, 8'h34, 32'h12345678);
    bus(1'b0, 8'h34, 32'h0);
    chk("sensor reg", 32'h12345678, q);
    chk("sensor out", 32'h12345678, slim);
  endtask
  task automatic t_pace();
    int g0;
    bus(1'b1, 8'h28, 32'h0);
    run <= 1'b1;
    repeat (40) @(posedge clk);
    g0 = grants;
    repeat (99) @(posedge clk);
    chk("free grants", 32'h1, 32'(grants - g0 >= 30));
    bus(1'b0, 8'h30, 32'h0);
    chk("link cur", 32'h1, 32'(q == 32'd6144 || q == 32'd7168));
    // 1024 byte packets at this limit leave 100 cycles between grants
    bus(1'b1, 8'h2c, 32'h7a120000);
    bus(1'b0, 8'h2c, 32'h0);
    chk("link limit", 32'h7a120000, q);
    bus(1'b1, 8'h28, 32'h1);
    repeat (300) @(posedge clk);
    g0 = grants;
    repeat (1000) @(posedge clk);
    chk("paced grants", 32'h1, 32'(grants - g0 inside {[9:11]}));
    bus(1'b1, 8'h2c, 32'h0);
    repeat (300) @(posedge clk);
    g0 = grants;
    repeat (300) @(posedge clk);
    chk("zero limit", 32'h0, 32'(grants - g0));
    run <= 1'b0;
    bus(1'b1, 8'h28, 32'h0);
  endtask
  task automatic t_locate();
    int c0;
    c0 = led_cyc;
    bus(1'b1, 8'h44, 32'h1);
    bus(1'b0, 8'h44, 32'h0);
    chk("locate busy", 32'h1, q);
    bus(1'b1, 8'h44, 32'h1);
    repeat (30) @(posedge clk);
    chk("flash length", 32'(FLASH), 32'(led_cyc - c0));
  endtask
  task automatic t_reset();
    int p0;
    p0 = pulses;
    bus(1'b1, 8'h28, 32'h1);
    bus(1'b1, 8'h38, 32'h1);
    repeat (4) @(posedge clk);
    chk("reset pulses", 32'h1, 32'(pulses - p0));
    bus(1'b0, 8'h34, 32'h0);
    chk("sensor rst", 32'h17d78400, q);
    chk("sensor out rst", 32'h17d78400, slim);
    bus(1'b0, 8'h28, 32'h0);
    chk("mode rst", 32'h0, q);
    bus(1'b0, 8'h84, 32'h0);
    chk("name rst", 32'h0, q);
  endtask
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_ident();
    t_name();
    t_stamp();
    t_temp();
    t_uptime();
    t_sensor();
    t_pace();
    t_locate();
    t_reset();
    give_verdict();
  end
  // the scenarios need some 2400 cycles; far beyond that means a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
endmodule // testbench
